// ==== inc/clk_route_pkg.sv ====
// Package with register map, field layout and types of the clock routing configuration block.
package clk_route_pkg;
  localparam logic [9:0] ADDR_PLL_CTRL = 10'h010;
  localparam logic [9:0] ADDR_PREDIV = 10'h1e0;
  localparam logic [9:0] ADDR_SRC_SEL = 10'h1e1;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  localparam logic [7:0] UPDATE_CODE = 8'h01;
  localparam int PWR_LSB = 0;
  localparam int POL_BIT = 7;
  localparam int BYP_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;
  localparam logic [1:0] PWR_RESET = PWR_DOWN;
  localparam logic [2:0] PREDIV_RESET = 3'h2;
  localparam logic BYP_RESET = 1'b0;
  localparam logic SRC_RESET = 1'b0;
  localparam logic POL_RESET = 1'b0;
  localparam logic [2:0] PREDIV_RATIO_MIN = 3'h2;
  localparam logic [2:0] PREDIV_RATIO_MAX = 3'h6;

  typedef struct packed {
    logic [1:0] pll_power;
    logic pfd_negative;
    logic [2:0] prediv_code;
    logic bypass_prediv;
    logic src_internal;
  } route_cfg_t;

  localparam route_cfg_t CFG_RESET = '{
    pll_power: PWR_RESET,
    pfd_negative: POL_RESET,
    prediv_code: PREDIV_RESET,
    bypass_prediv: BYP_RESET,
    src_internal: SRC_RESET
  };

  typedef struct packed {
    route_cfg_t pending;
    route_cfg_t active;
    logic [7:0] rdata;
    logic [2:0] ratio;
  } route_state_t;
endpackage

// ==== src/clock_source_routing_config.sv ====
// Clock source routing and PLL configuration registers with shadowed update.
`timescale 1ns/10ps
// Overview of operation
// R1: Power-up: PLL off, external clock through predivider.
// R2: Power field 01 powers PLL down, 00 runs.
// R3: Predivider ratio field defaults to 010, divide four.
// R4: Applied predivider ratio never below two.
// R5: Bypass bit zero feeds distribution from predivider.
// R6: Source bit zero selects external clock input.
// R7: New values apply only after writing 01 update.
// R8: All fields return to defaults on reset.
// R9: PLL with external input powers internal oscillator off.
// R10: Software sets power 00, external source for PLL.
// R11: Polarity bit zero positive, one negative.
// R12: Software keeps predivider above 1600 MHz input.
// R13: Bypass bit one feeds source directly.
// R14: Source bit one selects internal oscillator.
// R15: Update transfers all pending values together.
module clock_source_routing_config
  import clk_route_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port.
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Active routing controls.
  output logic o_pll_powerdown,
  output logic o_pfd_negative,
  output logic o_src_internal,
  output logic o_int_osc_enable,
  output logic o_bypass_prediv,
  output logic [2:0] o_prediv_ratio
);

  route_state_t state_reg;
  route_state_t state_next;

  // Division ratio for a predivider code; codes above four clamp to six.
  function automatic logic [2:0] ratio_of(input logic [2:0] code);
    logic [2:0] r;
    r = code + 3'h2;
    if (code > 3'h4) begin
      r = PREDIV_RATIO_MAX;
    end
    if (r < PREDIV_RATIO_MIN) begin
      r = PREDIV_RATIO_MIN;
    end
    return r;
  endfunction

  always_comb begin
    state_next = state_reg;
    state_next.rdata = 8'h00;
    if (i_wr) begin
      unique case (i_addr)
        ADDR_PLL_CTRL: begin
          state_next.pending.pll_power = i_wdata[PWR_LSB +: 2]; // [R2]
          state_next.pending.pfd_negative = i_wdata[POL_BIT]; // [R11]
        end
        ADDR_PREDIV: begin
          state_next.pending.prediv_code = i_wdata[2:0];
        end
        ADDR_SRC_SEL: begin
          state_next.pending.bypass_prediv = i_wdata[BYP_BIT]; // [R5] [R13]
          state_next.pending.src_internal = i_wdata[SRC_BIT]; // [R6] [R14]
        end
        ADDR_UPDATE: begin
          if (i_wdata == UPDATE_CODE) begin
            state_next.active = state_reg.pending; // [R7] [R15]
          end
        end
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        ADDR_PLL_CTRL: begin
          state_next.rdata = {state_reg.pending.pfd_negative, 5'h00,
                              state_reg.pending.pll_power};
        end
        ADDR_PREDIV: begin
          state_next.rdata = {5'h00, state_reg.pending.prediv_code};
        end
        ADDR_SRC_SEL: begin
          state_next.rdata = {6'h00, state_reg.pending.src_internal,
                              state_reg.pending.bypass_prediv};
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
    state_next.ratio = ratio_of(state_next.active.prediv_code); // [R3] [R4]
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '{pending: CFG_RESET, active: CFG_RESET, rdata: 8'h00,
                     ratio: 3'h4}; // [R1] [R8]
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_pll_powerdown = (state_reg.active.pll_power != PWR_NORMAL); // [R2]
  assign o_pfd_negative = state_reg.active.pfd_negative; // [R11]
  assign o_src_internal = state_reg.active.src_internal; // [R6] [R14]
  assign o_bypass_prediv = state_reg.active.bypass_prediv; // [R5] [R13]
  assign o_prediv_ratio = state_reg.ratio;
  // The internal oscillator runs only when it is the selected source.
  assign o_int_osc_enable = state_reg.active.src_internal; // [R9]

  a_reset_defaults: assert property (@(posedge i_clk) $fell(i_rst) |->
    o_pll_powerdown && !o_src_internal && !o_bypass_prediv && o_prediv_ratio == 3'h4)
    else $error("defaults wrong after reset"); // [R1] [R8]
  a_ratio_floor: assert property (@(posedge i_clk) disable iff (i_rst)
    o_prediv_ratio >= 3'h2 && o_prediv_ratio <= 3'h6)
    else $error("predivider ratio out of range"); // [R4]
  a_hold_until_update: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_wr && i_addr == ADDR_UPDATE && i_wdata == UPDATE_CODE) |=>
    $stable(o_src_internal) && $stable(o_bypass_prediv) && $stable(o_pll_powerdown))
    else $error("setting changed without update"); // [R7]
  a_update_applies: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == ADDR_UPDATE && i_wdata == UPDATE_CODE) |=>
    o_src_internal == $past(state_reg.pending.src_internal) &&
    o_pfd_negative == $past(state_reg.pending.pfd_negative) &&
    o_bypass_prediv == $past(state_reg.pending.bypass_prediv))
    else $error("update did not copy all settings"); // [R15]
  a_osc_off_external: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_src_internal |-> !o_int_osc_enable)
    else $error("internal oscillator on with external source"); // [R9]
  a_read_data: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == ADDR_SRC_SEL) |=> o_rdata[7:2] == 6'h00)
    else $error("reserved read bits not zero"); // [R13]
  a_power_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    o_pll_powerdown == (state_reg.active.pll_power != 2'h0))
    else $error("power state decode wrong"); // [R2]

  // A write of the update code to the update register.
  wire logic upd_hit = i_wr && (i_addr == ADDR_UPDATE) && (i_wdata == UPDATE_CODE);

  a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    !i_rd |=>
    o_rdata == 8'h00)
    else $error("read data not zero outside a read");

  a_rdata_on_write: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    i_wr |=>
    o_rdata == 8'h00)
    else $error("read data not zero after a write");

  a_read_pll_rsvd: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
    (i_rd && i_addr == ADDR_PLL_CTRL) |=>
    o_rdata[6:2] == 5'h00)
    else $error("power register reserved bits not zero");

  a_read_prediv_rsvd: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
    (i_rd && i_addr == ADDR_PREDIV) |=>
    o_rdata[7:3] == 5'h00)
    else $error("ratio register reserved bits not zero");

  a_read_update_zero: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    (i_rd && i_addr == ADDR_UPDATE) |=>
    o_rdata == 8'h00)
    else $error("update register read not zero");

  a_read_pll_value: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
    (i_rd && i_addr == ADDR_PLL_CTRL) |=>
    o_rdata[1:0] == $past(state_reg.pending.pll_power))
    else $error("power field read wrong");

  a_read_pol_value: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
    (i_rd && i_addr == ADDR_PLL_CTRL) |=>
    o_rdata[7] == $past(state_reg.pending.pfd_negative))
    else $error("polarity bit read wrong");

  a_read_prediv_value: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
    (i_rd && i_addr == ADDR_PREDIV) |=>
    o_rdata[2:0] == $past(state_reg.pending.prediv_code))
    else $error("ratio field read wrong");

  a_read_src_value: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
    (i_rd && i_addr == ADDR_SRC_SEL) |=>
    o_rdata[1:0] == {$past(state_reg.pending.src_internal), $past(state_reg.pending.bypass_prediv)})
    else $error("source bits read wrong");

  a_pend_power: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
    (i_wr && i_addr == ADDR_PLL_CTRL) |=>
    state_reg.pending.pll_power == $past(i_wdata[1:0]))
    else $error("power field not stored");

  a_pend_polarity: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
    (i_wr && i_addr == ADDR_PLL_CTRL) |=>
    state_reg.pending.pfd_negative == $past(i_wdata[POL_BIT]))
    else $error("polarity bit not stored");

  a_pend_prediv: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
    (i_wr && i_addr == ADDR_PREDIV) |=>
    state_reg.pending.prediv_code == $past(i_wdata[2:0]))
    else $error("ratio field not stored");

  a_pend_bypass: assert property (@(posedge i_clk) disable iff (i_rst) // [R13]
    (i_wr && i_addr == ADDR_SRC_SEL) |=>
    state_reg.pending.bypass_prediv == $past(i_wdata[BYP_BIT]))
    else $error("bypass bit not stored");

  a_pend_source: assert property (@(posedge i_clk) disable iff (i_rst) // [R14]
    (i_wr && i_addr == ADDR_SRC_SEL) |=>
    state_reg.pending.src_internal == $past(i_wdata[SRC_BIT]))
    else $error("source bit not stored");

  a_pend_unmapped: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    (i_wr && i_addr != ADDR_PLL_CTRL && i_addr != ADDR_PREDIV && i_addr != ADDR_SRC_SEL) |=>
    $stable(state_reg.pending))
    else $error("pending settings changed by other address");

  a_pend_hold: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    !i_wr |=>
    $stable(state_reg.pending))
    else $error("pending settings changed without a write");

  a_active_hold: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
    !i_wr |=>
    $stable(state_reg.active))
    else $error("active settings changed without a write");

  a_bad_update: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    (i_wr && i_addr == ADDR_UPDATE && i_wdata != UPDATE_CODE) |=>
    $stable(state_reg.active))
    else $error("wrong update code applied settings");

  a_ratio_hold: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    !upd_hit |=>
    $stable(o_prediv_ratio) && $stable(o_pfd_negative))
    else $error("ratio or polarity changed without update");

  a_update_whole: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
    upd_hit |=>
    state_reg.active == $past(state_reg.pending))
    else $error("update did not copy the whole setting");

  a_update_keeps: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
    upd_hit |=>
    $stable(state_reg.pending))
    else $error("update disturbed pending settings");

  a_update_ratio: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
    upd_hit |=>
    o_prediv_ratio == ratio_of($past(state_reg.pending.prediv_code)))
    else $error("update did not apply the ratio");

  a_update_power: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
    upd_hit |=>
    o_pll_powerdown == ($past(state_reg.pending.pll_power) != PWR_NORMAL))
    else $error("update did not apply the power state");

  a_ratio_small: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
    (state_reg.active.prediv_code <= 3'h4) |->
    o_prediv_ratio == 3'(state_reg.active.prediv_code + 3'h2))
    else $error("ratio not code plus two");

  a_ratio_clamp: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
    (state_reg.active.prediv_code > 3'h4) |->
    o_prediv_ratio == PREDIV_RATIO_MAX)
    else $error("large code not clamped");

  a_ratio_default: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
    (state_reg.active.prediv_code == PREDIV_RESET) |->
    o_prediv_ratio == 3'h4)
    else $error("default code not divide by four");

  a_osc_follow: assert property (@(posedge i_clk) disable iff (i_rst) // [R14]
    o_src_internal |->
    o_int_osc_enable)
    else $error("internal oscillator off while selected");

  a_pll_external: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
    (!o_pll_powerdown && !o_src_internal) |->
    !o_int_osc_enable)
    else $error("internal oscillator on with external loop");

  a_reset_pending: assert property (@(posedge i_clk) // [R8]
    $fell(i_rst) |->
    state_reg.pending == CFG_RESET)
    else $error("pending settings not default after reset");

  a_reset_outputs: assert property (@(posedge i_clk) // [R1]
    $fell(i_rst) |->
    !o_pfd_negative && !o_int_osc_enable && o_rdata == 8'h00)
    else $error("outputs not default after reset");

  a_reset_pll_off: assert property (@(posedge i_clk) // [R2]
    $fell(i_rst) |->
    state_reg.active.pll_power == PWR_DOWN)
    else $error("power field not default after reset");
endmodule

// ==== tb/clk_path_model.sv ====
// Model of the clock path that the routing controls steer.
`timescale 1ns/10ps
module clk_path_model (
  // Routing controls.
  input wire logic i_bypass_prediv,
  input wire logic [2:0] i_prediv_ratio,
  // Division seen ahead of the channel dividers.
  output logic [2:0] o_feed_div
);
  assign o_feed_div = i_bypass_prediv ? 3'h1 : i_prediv_ratio;
endmodule

// ==== tb/clock_source_routing_config_tb.sv ====
// Self-checking testbench of the clock routing configuration block.
`timescale 1ns/10ps
module clock_source_routing_config_tb;
  import clk_route_pkg::*;
  logic i_clk = 0;
  logic i_rst = 1;
  logic i_wr = 0;
  logic i_rd = 0;
  logic [9:0] i_addr = '0;
  logic [7:0] i_wdata = '0;
  logic [7:0] o_rdata;
  logic o_pll_powerdown, o_pfd_negative, o_src_internal, o_int_osc_enable, o_bypass_prediv;
  logic [2:0] o_prediv_ratio;
  logic [2:0] feed;
  int errors = 0;
  int compares = 0;
  wire logic [7:0] outs = {o_pll_powerdown, o_pfd_negative, o_src_internal,
    o_int_osc_enable, o_bypass_prediv, o_prediv_ratio};
  always #4 i_clk = ~i_clk;
  clock_source_routing_config DUT (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_pll_powerdown, .o_pfd_negative, .o_src_internal, .o_int_osc_enable,
    .o_bypass_prediv, .o_prediv_ratio);
  clk_path_model path (.i_bypass_prediv(o_bypass_prediv), .i_prediv_ratio(o_prediv_ratio),
    .o_feed_div(feed));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
    #1;
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    #1;
    chk("rdata", o_rdata, e);
  endtask
  task results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_defaults;
    chk("outputs", outs, 8'h84);
    chk("feed", {5'h0, feed}, 8'h04);
    rd(ADDR_PLL_CTRL, 8'h01);
    rd(ADDR_PREDIV, 8'h02);
    rd(ADDR_SRC_SEL, 8'h00);
    $display("test defaults done");
  endtask
  task t_update;
    wr(ADDR_SRC_SEL, 8'h03);
    wr(ADDR_PLL_CTRL, 8'h80);
    wr(ADDR_PREDIV, 8'h00);
    wr(ADDR_UPDATE, 8'h02);
    wr(10'h155, 8'hff);
    chk("held", outs, 8'h84);
    rd(ADDR_PLL_CTRL, 8'h80);
    rd(ADDR_SRC_SEL, 8'h03);
    wr(ADDR_UPDATE, UPDATE_CODE);
    chk("applied", outs, 8'h7a);
    chk("feed", {5'h0, feed}, 8'h01);
    rd(ADDR_UPDATE, 8'h00);
    rd(10'h155, 8'h00);
    $display("test update done");
  endtask
  task t_ratio;
    wr(ADDR_SRC_SEL, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_PREDIV, 8'(c));
      wr(ADDR_UPDATE, UPDATE_CODE);
      chk("ratio", {5'h0, o_prediv_ratio}, (c > 4) ? 8'h06 : 8'(c + 2));
    end
    chk("ext pll", {5'h0, o_pll_powerdown, o_src_internal, o_int_osc_enable}, 8'h00);
    wr(ADDR_PLL_CTRL, 8'h03);
    wr(ADDR_UPDATE, UPDATE_CODE);
    chk("pll off", {7'h0, o_pll_powerdown}, 8'h01);
    $display("test ratio done");
  endtask
  task t_reset2;
    @(posedge i_clk);
    i_rst <= 1;
    @(posedge i_clk);
    i_rst <= 0;
    #1;
    chk("outputs", outs, 8'h84);
    rd(ADDR_PLL_CTRL, 8'h01);
    $display("test reset done");
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    t_defaults;
    t_update;
    t_ratio;
    t_reset2;
    results;
  end
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule
